// File: rtl/seesl_pkg.sv
// Package: constants, states and carriers of the serial EEPROM slave
package seesl_pkg;

   // ==========================================================
   // Array and cache geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int CACHE_IDX_W = 6;
   localparam int LINE_W = 3;
   localparam int BLK_MSB = 12;
   localparam int BLK_LSB = 9;

   // ==========================================================
   // Control, address and configuration byte fields
   localparam int CTRL_RW_BIT = 0;
   localparam int ADDR_CFG_BIT = 7;
   localparam int CFG_SEL_BIT = 7;
   localparam int CFG_READ_BIT = 6;
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5; // Arbitrary value
   localparam logic [3:0] CFG_READ_FILL = 4'hf;

   // ==========================================================
   // Values after reset
   localparam logic [3:0] HE_BLOCK_RESET = 4'hf;
   localparam logic [3:0] SEC_START_RESET = 4'hf;
   localparam logic [3:0] SEC_LEN_RESET = 4'h0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int WR_TIME_US = 5000;
   localparam int WR_CYCLES = (WR_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;
   localparam int BIT_ACK = 8;
   localparam int BIT_LAST = 7;

   // ==========================================================
   // States and carriers
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CTRL = 4'h1,
      ST_ADDR_HI = 4'h3,
      ST_ADDR_LO = 4'h2,
      ST_WDATA = 4'h6,
      ST_READ = 4'h7,
      ST_CFG2 = 4'h5,
      ST_CFG3 = 4'h4,
      ST_IGNORE = 4'hc
   } seesl_bus_state_type;

   typedef enum logic [1:0] {
      CM_IDLE = 2'h0,
      CM_BYTE = 2'h1,
      CM_TIME = 2'h3
   } seesl_commit_state_type;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } seesl_wr_type;

endpackage

// File: rtl/seesl_array.sv
// Memory array with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none

module seesl_array #(
   parameter int ADDR_W = seesl_pkg::ADDR_W,
   parameter int DATA_W = seesl_pkg::DATA_W
) (
   // Clock
   input wire logic clk_sys_in,
   // Write request
   input wire seesl_pkg::seesl_wr_type wr_in,
   // Read port
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [DATA_W-1:0] rd_data_out
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk_sys_in) begin
      if (wr_in.en) begin
         mem[wr_in.addr] <= wr_in.data;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      rd_data_out <= mem[rd_addr_in];
   end

endmodule

`default_nettype wire

// File: rtl/seesl_slave.sv
// Two-wire serial EEPROM slave with page cache, security and endurance
//
// Notes on behaviour
// - Up to 64 bytes cached, written after Stop.
// - Data bytes step only low six pointer bits.
// - Byte counter wraps into next cache line.
// - Full cache wraps to line 0, overwriting.
// - Stop starts write cycle; cache captures until then.
// - Current read returns last address plus one.
// - Master nack then Stop ends read; release.
// - Address latched before repeated Start ends write.
// - Master ack fetches next byte; pointer increments.
// - Config bit 7 low relocates endurance block.
// - Endurance block never protected.
// - No relocation after security set; default top.
// - Protection 0-15 blocks, settable only once.
// - Security command: start block in bits 1-4.
// - Third byte holds block count in bits 0-3.
// - Range stored whole; endurance block stays open.
// - Protected bytes silently skipped on write.
// - Config read returns start and count nibbles.
// - No ack to control byte while busy.
// - Respond only when chip select pins match.
// - Word address: two bytes, thirteen bits used.
// - Write cycle lasts one period per loaded page.
`timescale 1ns/1ps
`default_nettype none

module seesl_slave #(
   parameter logic [3:0] DEV_TYPE = seesl_pkg::DEV_TYPE_DEFAULT,
   parameter int WR_CYCLES = seesl_pkg::WR_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Chip address pins
   input wire logic chip_select_bit0_in,
   input wire logic chip_select_bit1_in,
   input wire logic chip_select_bit2_in,
   // Status
   output logic busy_out,
   output logic [3:0] he_block_out,
   output logic [3:0] sec_start_out,
   output logic [3:0] sec_len_out
);

   localparam int AW = seesl_pkg::ADDR_W;
   localparam int TW = seesl_pkg::TIMER_W;

   // ==========================================================
   // Helper functions
   function automatic logic [AW-1:0] cache_target(
      input logic [AW-1:0] start,
      input logic [5:0] idx
   );
      logic [2:0] page;
      page = start[5:3] + idx[5:3];
      return {start[AW-1:6], page, idx[2:0]};
   endfunction

   function automatic logic is_protected(
      input logic [AW-1:0] addr,
      input logic [3:0] start,
      input logic [3:0] len,
      input logic [3:0] he
   );
      logic [3:0] blk;
      logic [4:0] stop_blk;
      blk = addr[seesl_pkg::BLK_MSB:seesl_pkg::BLK_LSB];
      stop_blk = {1'b0, start} + {1'b0, len};
      return (len != 4'h0) && (blk >= start)
         && ({1'b0, blk} < stop_blk) && (blk != he);
   endfunction

   // ==========================================================
   // Pin synchronisers and edge detection
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic [2:0] cs_meta_reg;
   logic [2:0] cs_reg;
   logic scl_d_reg;
   logic sda_d_reg;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         cs_meta_reg <= 3'h0;
         cs_reg <= 3'h0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         cs_meta_reg <= {chip_select_bit2_in, chip_select_bit1_in,
            chip_select_bit0_in};
         cs_reg <= cs_meta_reg;
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];
   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

   // ==========================================================
   // Shared state
   seesl_pkg::seesl_bus_state_type state_reg;
   seesl_pkg::seesl_commit_state_type cm_state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] tx_sh_reg;
   logic sda_low_reg;
   logic mack_reg;
   logic first_rd_reg;
   logic [AW-1:0] addr_ptr_reg;
   logic [4:0] addr_hi_reg;
   logic [AW-1:0] start_addr_reg;
   logic [5:0] cptr_reg;
   logic [63:0] cvalid_reg;
   logic [7:0] cache_mem [0:63];
   logic wr_pending_reg;
   logic [3:0] he_blk_reg;
   logic [3:0] sec_start_reg;
   logic [3:0] sec_len_reg;
   logic [3:0] cfg_blk_reg;
   logic cfg_rd_reg;
   logic cfg_idx_reg;
   logic [2:0] cm_line_reg;
   logic [2:0] cm_byte_reg;
   logic cm_line_used_reg;
   logic [TW-1:0] timer_reg;
   logic [7:0] rd_data;

   logic busy;
   logic tx_mode;
   logic byte_done;
   logic ack_slot_end;
   logic ctrl_match;
   logic ack_now;
   logic load_tx;
   logic [7:0] tx_byte;

   assign busy = (cm_state_reg != seesl_pkg::CM_IDLE);
   assign tx_mode = (state_reg == seesl_pkg::ST_READ);
   assign byte_done = scl_fall && !tx_mode
      && (bit_cnt_reg == 4'(seesl_pkg::BIT_LAST));
   assign ack_slot_end = scl_fall
      && (bit_cnt_reg == 4'(seesl_pkg::BIT_ACK));
   assign ctrl_match = (rx_sh_reg[7:4] == DEV_TYPE)
      && (rx_sh_reg[3:1] == cs_reg)
      && !busy;
   assign load_tx = ack_slot_end && tx_mode
      && (first_rd_reg || mack_reg);

   always_comb begin
      case (state_reg)
         seesl_pkg::ST_CTRL: ack_now = byte_done && ctrl_match;
         seesl_pkg::ST_ADDR_HI,
         seesl_pkg::ST_ADDR_LO,
         seesl_pkg::ST_WDATA,
         seesl_pkg::ST_CFG2,
         seesl_pkg::ST_CFG3: ack_now = byte_done;
         default: ack_now = 1'b0;
      endcase
   end

   always_comb begin
      if (cfg_rd_reg) begin
         tx_byte = {seesl_pkg::CFG_READ_FILL,
            cfg_idx_reg ? sec_len_reg : sec_start_reg};
      end else begin
         tx_byte = rd_data;
      end
   end

   // ==========================================================
   // Bit level: counter, shifters and data line drive
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         bit_cnt_reg <= 4'h0;
         rx_sh_reg <= 8'h00;
         tx_sh_reg <= 8'hff;
         sda_low_reg <= 1'b0;
         mack_reg <= 1'b0;
      end else if (start_cond || stop_cond) begin
         // Start's own SCL fall then brings the count to zero
         bit_cnt_reg <= start_cond ? 4'hf : 4'h0;
         sda_low_reg <= 1'b0;
      end else if (scl_rise) begin
         if (bit_cnt_reg < 4'(seesl_pkg::BIT_ACK)) begin
            rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
         end else begin
            mack_reg <= !sda_s;
         end
      end else if (scl_fall) begin
         if (bit_cnt_reg == 4'(seesl_pkg::BIT_ACK)) begin
            bit_cnt_reg <= 4'h0;
            if (load_tx) begin
               tx_sh_reg <= tx_byte;
               sda_low_reg <= !tx_byte[7];
            end else begin
               sda_low_reg <= 1'b0;
            end
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(seesl_pkg::BIT_LAST)) begin
               sda_low_reg <= ack_now;
            end else if (tx_mode) begin
               tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
               sda_low_reg <= !tx_sh_reg[6];
            end
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = sda_low_reg;

   // ==========================================================
   // Byte level state machine and address pointer
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_reg <= seesl_pkg::ST_IDLE;
         addr_ptr_reg <= '0;
         addr_hi_reg <= 5'h00;
         first_rd_reg <= 1'b0;
      end else if (start_cond) begin
         state_reg <= seesl_pkg::ST_CTRL;
      end else if (stop_cond) begin
         state_reg <= seesl_pkg::ST_IDLE;
      end else if (byte_done) begin
         case (state_reg)
            seesl_pkg::ST_CTRL: begin
               if (!ctrl_match) begin
                  state_reg <= seesl_pkg::ST_IGNORE;
               end else if (rx_sh_reg[seesl_pkg::CTRL_RW_BIT]) begin
                  state_reg <= seesl_pkg::ST_READ;
                  first_rd_reg <= 1'b1;
               end else begin
                  state_reg <= seesl_pkg::ST_ADDR_HI;
               end
            end
            seesl_pkg::ST_ADDR_HI: begin
               if (rx_sh_reg[seesl_pkg::ADDR_CFG_BIT]) begin
                  state_reg <= seesl_pkg::ST_CFG2;
               end else begin
                  addr_hi_reg <= rx_sh_reg[4:0];
                  state_reg <= seesl_pkg::ST_ADDR_LO;
               end
            end
            seesl_pkg::ST_ADDR_LO: begin
               addr_ptr_reg <= {addr_hi_reg, rx_sh_reg};
               state_reg <= seesl_pkg::ST_WDATA;
            end
            seesl_pkg::ST_WDATA: begin
               addr_ptr_reg <= {addr_ptr_reg[AW-1:6],
                  addr_ptr_reg[5:0] + 6'h01};
            end
            seesl_pkg::ST_CFG2: state_reg <= seesl_pkg::ST_CFG3;
            seesl_pkg::ST_CFG3: state_reg <= seesl_pkg::ST_IGNORE;
            default: state_reg <= seesl_pkg::ST_IGNORE;
         endcase
      end else if (ack_slot_end && tx_mode) begin
         first_rd_reg <= 1'b0;
         if (!load_tx) begin
            state_reg <= seesl_pkg::ST_IGNORE;
         end else if (!cfg_rd_reg) begin
            addr_ptr_reg <= addr_ptr_reg + 13'h0001;
         end
      end
   end

   // ==========================================================
   // Page cache capture
   always_ff @(posedge clk_sys_in) begin
      if (byte_done && (state_reg == seesl_pkg::ST_WDATA)) begin
         cache_mem[cptr_reg] <= rx_sh_reg;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cptr_reg <= 6'h00;
         cvalid_reg <= 64'h0;
         start_addr_reg <= '0;
         wr_pending_reg <= 1'b0;
      end else if (start_cond || stop_cond) begin
         wr_pending_reg <= 1'b0;
      end else if (byte_done && (state_reg == seesl_pkg::ST_ADDR_LO)) begin
         start_addr_reg <= {addr_hi_reg, rx_sh_reg};
         cptr_reg <= {3'h0, rx_sh_reg[2:0]};
         cvalid_reg <= 64'h0;
      end else if (byte_done && (state_reg == seesl_pkg::ST_WDATA)) begin
         cvalid_reg[cptr_reg] <= 1'b1;
         cptr_reg <= cptr_reg + 6'h01;
         wr_pending_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Security and endurance configuration
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         he_blk_reg <= seesl_pkg::HE_BLOCK_RESET;
         sec_start_reg <= seesl_pkg::SEC_START_RESET;
         sec_len_reg <= seesl_pkg::SEC_LEN_RESET;
         cfg_blk_reg <= 4'h0;
         cfg_rd_reg <= 1'b0;
         cfg_idx_reg <= 1'b0;
      end else if (stop_cond) begin
         cfg_rd_reg <= 1'b0;
         cfg_idx_reg <= 1'b0;
      end else if (byte_done && (state_reg == seesl_pkg::ST_ADDR_HI)) begin
         cfg_blk_reg <= rx_sh_reg[4:1];
      end else if (byte_done && (state_reg == seesl_pkg::ST_CFG3)) begin
         if (rx_sh_reg[seesl_pkg::CFG_READ_BIT]) begin
            cfg_rd_reg <= 1'b1;
            cfg_idx_reg <= 1'b0;
         end else if (sec_len_reg != 4'h0) begin
            cfg_rd_reg <= 1'b0;
         end else if (rx_sh_reg[seesl_pkg::CFG_SEL_BIT]) begin
            sec_start_reg <= cfg_blk_reg;
            sec_len_reg <= rx_sh_reg[3:0];
         end else begin
            he_blk_reg <= cfg_blk_reg;
         end
      end else if (load_tx && cfg_rd_reg && first_rd_reg) begin
         cfg_idx_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Internal write cycle: cache to array, one timed slot per loaded page
   logic [5:0] cm_idx;
   logic [AW-1:0] cm_addr;
   logic line_used;
   seesl_pkg::seesl_wr_type wr_req;

   assign cm_idx = {cm_line_reg, cm_byte_reg};
   assign cm_addr = cache_target(start_addr_reg, cm_idx);
   assign line_used = cm_line_used_reg || cvalid_reg[cm_idx];
   assign wr_req.en = (cm_state_reg == seesl_pkg::CM_BYTE)
      && cvalid_reg[cm_idx]
      && !is_protected(cm_addr, sec_start_reg, sec_len_reg,
         he_blk_reg);
   assign wr_req.addr = cm_addr;
   assign wr_req.data = cache_mem[cm_idx];

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cm_state_reg <= seesl_pkg::CM_IDLE;
         cm_line_reg <= 3'h0;
         cm_byte_reg <= 3'h0;
         cm_line_used_reg <= 1'b0;
         timer_reg <= '0;
      end else begin
         case (cm_state_reg)
            seesl_pkg::CM_IDLE: begin
               if (stop_cond && wr_pending_reg) begin
                  cm_state_reg <= seesl_pkg::CM_BYTE;
                  cm_line_reg <= 3'h0;
                  cm_byte_reg <= 3'h0;
                  cm_line_used_reg <= 1'b0;
               end
            end
            seesl_pkg::CM_BYTE: begin
               cm_byte_reg <= cm_byte_reg + 3'h1;
               cm_line_used_reg <= line_used;
               if (cm_byte_reg == 3'h7) begin
                  cm_line_used_reg <= 1'b0;
                  if (line_used) begin
                     cm_state_reg <= seesl_pkg::CM_TIME;
                     timer_reg <= TW'(WR_CYCLES - 1);
                  end else if (cm_line_reg == 3'h7) begin
                     cm_state_reg <= seesl_pkg::CM_IDLE;
                  end else begin
                     cm_line_reg <= cm_line_reg + 3'h1;
                  end
               end
            end
            seesl_pkg::CM_TIME: begin
               timer_reg <= timer_reg - TW'(1);
               if (timer_reg == '0) begin
                  if (cm_line_reg == 3'h7) begin
                     cm_state_reg <= seesl_pkg::CM_IDLE;
                  end else begin
                     cm_line_reg <= cm_line_reg + 3'h1;
                     cm_state_reg <= seesl_pkg::CM_BYTE;
                  end
               end
            end
            default: cm_state_reg <= seesl_pkg::CM_IDLE;
         endcase
      end
   end

   seesl_array #(
      .ADDR_W(AW),
      .DATA_W(seesl_pkg::DATA_W)
   ) u_array (
      .clk_sys_in(clk_sys_in),
      .wr_in(wr_req),
      .rd_addr_in(addr_ptr_reg),
      .rd_data_out(rd_data)
   );

   // ==========================================================
   // Status outputs
   assign busy_out = busy;
   assign he_block_out = he_blk_reg;
   assign sec_start_out = sec_start_reg;
   assign sec_len_out = sec_len_reg;

endmodule

`default_nettype wire

// File: sim/seesl_slave_sva.sv
// Concurrent checks on the ports of the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module seesl_slave_sva #(
   parameter int WR_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_out,
   // Status
   input wire logic busy_out,
   input wire logic [3:0] he_block_out,
   input wire logic [3:0] sec_start_out,
   input wire logic [3:0] sec_len_out
);
   // ======
   // Length of the current busy spell
   localparam int BUSY_MAX = 8 * (WR_CYCLES + 8) + 16;
   int busy_cnt;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !busy_out) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // ======
   // Properties
   sequence s_busy_start;
      !busy_out ##1 busy_out;
   endsequence
   property p_reset_vals;
      $fell(rst_in) |-> he_block_out == 4'hf && sec_start_out == 4'hf
         && sec_len_out == 4'h0 && !busy_out && !sda_oe_out;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("bad value after reset");
   property p_busy_from_stop;
      s_busy_start |-> scl_in && sda_in;
   endproperty
   a_busy_from_stop: assert property (p_busy_from_stop)
      else $error("busy rose off a stop");
   property p_busy_quiet;
      busy_out |-> !sda_oe_out;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("drive while busy");
   property p_oe_timing;
      !$past(rst_in) && $changed(sda_oe_out)
         |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2);
   endproperty
   a_oe_timing: assert property (p_oe_timing)
      else $error("drive changed near clock high");
   property p_len_locked;
      !$past(rst_in) && $past(sec_len_out) != 4'h0
         |-> $stable(sec_len_out) && $stable(sec_start_out);
   endproperty
   a_len_locked: assert property (p_len_locked)
      else $error("protection changed twice");
   property p_he_locked;
      !$past(rst_in) && $past(sec_len_out) != 4'h0 |-> $stable(he_block_out);
   endproperty
   a_he_locked: assert property (p_he_locked)
      else $error("endurance block moved");
   property p_cfg_when;
      !$past(rst_in) && ($changed(he_block_out) || $changed(sec_start_out)
         || $changed(sec_len_out)) |-> !scl_in && !busy_out;
   endproperty
   a_cfg_when: assert property (p_cfg_when)
      else $error("setting changed out of place");
   property p_busy_len;
      !$past(rst_in) && $fell(busy_out)
         |-> busy_cnt >= WR_CYCLES && busy_cnt <= BUSY_MAX;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write cycle length off");
endmodule
bind seesl_slave seesl_slave_sva #(.WR_CYCLES(WR_CYCLES)) u_sva (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
   .sda_in(sda_in), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
   .he_block_out(he_block_out), .sec_start_out(sec_start_out),
   .sec_len_out(sec_len_out));
`default_nettype wire

// File: sim/seesl_master.sv
// Two-wire bus master model that clocks and commands the slave
`timescale 1ns/1ps
`default_nettype none
module seesl_master (
   // Clock
   input wire logic clk_in,
   // Bus
   input wire logic sda_in,
   output var logic scl_out = 1'b1,
   output var logic sda_out = 1'b1
);
   // ======
   // Bus primitives, one bit lasts eight clocks
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic start;
      w(2);
      sda_out <= 1'b1;
      w(2);
      scl_out <= 1'b1;
      w(4);
      sda_out <= 1'b0;
      w(4);
      scl_out <= 1'b0;
   endtask
   task automatic stop;
      w(2);
      sda_out <= 1'b0;
      w(2);
      scl_out <= 1'b1;
      w(4);
      sda_out <= 1'b1;
      w(4);
   endtask
   task automatic bitx(input logic b, output logic r);
      w(2);
      sda_out <= b;
      w(2);
      scl_out <= 1'b1;
      w(2);
      r = sda_in;
      w(2);
      scl_out <= 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   // Nack on the last byte lets the slave release the line
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(~ack, r);
   endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WRC = 20;
   localparam logic [2:0] PINS = 3'h5;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   wire logic scl;
   wire logic m_sda;
   wire logic oe;
   wire logic sdo;
   wire logic sda = m_sda & (sdo | ~oe);
   logic [2:0] cs = PINS;
   wire logic busy;
   wire logic [3:0] he;
   wire logic [3:0] ss;
   wire logic [3:0] sl;
   int n_fail = 0;
   int comparisons = 0;
   always #50 clk_sys_in = ~clk_sys_in;
   seesl_master M (.clk_in(clk_sys_in), .sda_in(sda), .scl_out(scl),
      .sda_out(m_sda));
   seesl_slave #(.WR_CYCLES(WRC)) DUT (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
      .sda_oe_out(oe), .chip_select_bit0_in(cs[0]),
      .chip_select_bit1_in(cs[1]), .chip_select_bit2_in(cs[2]),
      .busy_out(busy), .he_block_out(he), .sec_start_out(ss),
      .sec_len_out(sl));
   // ======
   // Checking and bus helpers
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [7:0] ctl(input logic [2:0] s, input logic r);
      return {seesl_pkg::DEV_TYPE_DEFAULT, s, r};
   endfunction
   task automatic wr(input logic [7:0] d);
      logic a;
      M.wbyte(d, a);
      chk("ack", 8'h01, {7'h0, a});
   endtask
   task automatic rd(input logic [7:0] e, input logic ack);
      logic [7:0] d;
      M.rbyte(ack, d);
      chk("data", e, d);
   endtask
   task automatic hdr(input logic [12:0] ad, input logic r);
      M.start();
      wr(ctl(PINS, 1'b0));
      wr({3'h0, ad[12:8]});
      wr(ad[7:0]);
      if (r) begin
         M.start();
         wr(ctl(PINS, 1'b1));
      end
   endtask
   task automatic poll(input logic b);
      logic a;
      int n;
      n = 0;
      do begin
         n++;
         M.start();
         M.wbyte(ctl(PINS, 1'b0), a);
         M.stop();
      end while (a !== 1'b1 && n < 40);
      if (b) chk("busy nack", 8'h01, {7'h0, n > 1});
      chk("ready", 8'h01, {7'h0, a});
   endtask
   task automatic put(input logic [12:0] ad, input logic [7:0] d);
      hdr(ad, 1'b0);
      wr(d);
      M.stop();
      poll(1'b0);
   endtask
   task automatic get(input logic [12:0] ad, input logic [7:0] e);
      hdr(ad, 1'b1);
      rd(e, 1'b0);
      M.stop();
      chk("release", 8'h00, {7'h0, oe});
   endtask
   // Settings command; a read request is left open for the read phase
   task automatic cfg(input logic [7:0] hi, input logic [7:0] c);
      M.start();
      wr(ctl(PINS, 1'b0));
      wr(hi);
      wr(8'h00);
      wr(c);
      if (!c[6]) begin
         M.stop();
         poll(1'b0);
      end
   endtask
   task automatic rdcfg(input logic [3:0] s, input logic [3:0] l);
      cfg(8'h80, 8'hc0);
      M.start();
      wr(ctl(PINS, 1'b1));
      rd({4'hf, s}, 1'b1);
      rd({4'hf, l}, 1'b0);
      M.stop();
   endtask
   // ======
   // Scenarios
   task automatic t_reset;
      chk("he", 8'h0f, {4'h0, he});
      chk("start", 8'h0f, {4'h0, ss});
      chk("len", 8'h00, {4'h0, sl});
      chk("busy", 8'h00, {7'h0, busy});
   endtask
   task automatic t_select;
      logic a;
      for (int s = 0; s < 8; s++) begin
         M.start();
         M.wbyte(ctl(s[2:0], 1'b0), a);
         M.stop();
         chk("select", {7'h0, s[2:0] == PINS}, {7'h0, a});
      end
      cs <= 3'h2;
      M.start();
      M.wbyte(ctl(3'h2, 1'b0), a);
      M.stop();
      chk("moved select", 8'h01, {7'h0, a});
      cs <= PINS;
      M.start();
      M.wbyte({~seesl_pkg::DEV_TYPE_DEFAULT, PINS, 1'b0}, a);
      M.stop();
      chk("type", 8'h00, {7'h0, a});
   endtask
   task automatic t_wrap;
      hdr(13'h013c, 1'b0);
      for (int i = 0; i < 6; i++) wr(8'h30 + i[7:0]);
      M.stop();
      poll(1'b1);
      hdr(13'h013c, 1'b1);
      for (int i = 0; i < 4; i++) rd(8'h30 + i[7:0], i < 3);
      M.stop();
      hdr(13'h0100, 1'b1);
      rd(8'h34, 1'b1);
      rd(8'h35, 1'b0);
      M.stop();
   endtask
   task automatic t_full;
      hdr(13'h0200, 1'b0);
      for (int i = 0; i < 66; i++) wr(i[7:0] ^ 8'h5a);
      M.stop();
      poll(1'b1);
      hdr(13'h0200, 1'b1);
      for (int j = 0; j < 63; j++)
         rd((j < 2 ? j[7:0] + 8'h40 : j[7:0]) ^ 8'h5a, j < 62);
      M.stop();
      M.start();
      wr(ctl(PINS, 1'b1));
      rd(8'h3f ^ 8'h5a, 1'b0);
      M.stop();
   endtask
   task automatic t_secure;
      rdcfg(4'hf, 4'h0);
      put(13'h0a00, 8'h11);
      cfg(8'h8c, 8'h00);
      chk("he set", 8'h06, {4'h0, he});
      cfg(8'hea, 8'hb3);
      cfg(8'h82, 8'h81);
      cfg(8'h84, 8'h00);
      chk("he kept", 8'h06, {4'h0, he});
      rdcfg(4'h5, 4'h3);
      put(13'h0a00, 8'h22);
      put(13'h0c00, 8'h33);
      put(13'h0800, 8'h44);
      get(13'h0a00, 8'h11);
      get(13'h0c00, 8'h33);
      get(13'h0800, 8'h44);
   endtask
   // ======
   // Main sequence and watchdog
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      t_reset();
      t_select();
      t_wrap();
      t_full();
      t_secure();
      conclude();
   end
   initial begin
      repeat (80000) @(posedge clk_sys_in);
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
